// [rtl/serial_port.sv]
// Serial port receive status, data registers, transmitter and APB slave.
// Assumes an APB master on pclk and an asynchronous line on rx_line.
//
// Summary of operation
// - Address-detect drops characters with ninth bit clear, only in 9-bit mode.
// - Receiver idle flag reads 1 when idle, 0 while receiving.
// - Parity error flag belongs to the character at the FIFO head.
// - Framing error flag belongs to the character at the FIFO head.
// - Overrun sets when a character arrives to a full buffer; stays set.
// - Software clearing overrun empties buffer and shift register; cannot set it.
// - Data-available reads 1 while the buffer holds a character.
// - Transmit bit 8 supplies the ninth bit in 9-bit mode.
// - Transmit bits 7:0 supply the lower eight data bits.
// - Receive bit 8 returns the head character's ninth bit.
// - Receive bits 7:0 return the head data, zero after reset.
// - Data register bits 15:9 read as zero.
// - Receive buffer holds four characters besides the shift register.
`timescale 1ns/1ps
`include "serial_defs.svh"
module serial_port #(
  parameter int CLKS_PER_BIT = `BAUD_DIV,
  parameter int DEPTH        = `RX_DEPTH
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_line,
  output logic             tx_line,
  output logic             irq
);
  localparam logic [15:0] BIT_LAST  = 16'(CLKS_PER_BIT - 1);
  localparam logic [15:0] HALF_LAST = 16'(CLKS_PER_BIT / 2 - 1);
  localparam logic [2:0]  FULL      = 3'(DEPTH);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic                   sync1_reg, sync2_reg;
  serial_pkg::rx_state_t  rx_st_reg, rx_st_next;
  logic [15:0]            rx_cnt_reg, rx_cnt_next;
  logic [3:0]             rx_bit_reg, rx_bit_next;
  logic [8:0]             rx_sh_reg, rx_sh_next;
  logic                   rx_par_reg, rx_par_next;
  logic                   rx_parity_error_flag_reg, rx_parity_error_flag_next;
  logic                   rx_done, rx_framing_error_flag, keep, push, pop, flush, ovr_set;
  logic [10:0]            mem [DEPTH];
  logic [1:0]             wp_reg, wp_next, rp_reg, rp_next;
  logic [2:0]             fcnt_reg, fcnt_next;
  logic [10:0]            head;
  serial_pkg::tx_state_t  tx_st_reg, tx_st_next;
  logic [10:0]            tx_sh_reg, tx_sh_next;
  logic [3:0]             tx_left_reg, tx_left_next;
  logic [15:0]            tx_cnt_reg, tx_cnt_next;
  logic [8:0]             th_reg, th_next;
  logic                   thv_reg, thv_next, tx_load, tx_done;
  logic                   address_detect_enable_reg, address_detect_enable_next, ovr_reg, ovr_next;
  logic [2:0]             cfg_reg, cfg_next;
  logic [`NINTR-1:0]      ist_reg, ist_next, imsk_reg, imsk_next, ev;
  logic [31:0]            prdata_reg, prdata_next, rd_val;
  logic                   wr, rd, hit, nine;

  ////////////////////////////////////////////////////////////////////////////
  // Line synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
    end else begin
      sync1_reg <= rx_line;
      sync2_reg <= sync1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive shift register: start, data, optional parity, stop
  assign nine = cfg_reg[`CFG_NINE];
  always_comb begin
    rx_st_next   = rx_st_reg;
    rx_cnt_next  = rx_cnt_reg;
    rx_bit_next  = rx_bit_reg;
    rx_sh_next   = rx_sh_reg;
    rx_par_next  = rx_par_reg;
    rx_parity_error_flag_next = rx_parity_error_flag_reg;
    rx_done      = 1'b0;
    rx_framing_error_flag      = 1'b0;
    if (rx_cnt_reg != 16'h0000) rx_cnt_next = rx_cnt_reg - 16'h0001;
    case (rx_st_reg)
      serial_pkg::RX_IDLE: if (!sync2_reg) begin
        rx_st_next  = serial_pkg::RX_START;
        rx_cnt_next = HALF_LAST;
      end
      serial_pkg::RX_START: if (rx_cnt_reg == 16'h0000) begin
        // A start bit gone high by mid-bit was a glitch
        rx_st_next   = sync2_reg ? serial_pkg::RX_IDLE : serial_pkg::RX_DATA;
        rx_cnt_next  = BIT_LAST;
        rx_bit_next  = 4'h0;
        rx_sh_next   = 9'h000;
        rx_par_next  = 1'b0;
        rx_parity_error_flag_next = 1'b0;
      end
      serial_pkg::RX_DATA: if (rx_cnt_reg == 16'h0000) begin
        rx_sh_next[rx_bit_reg] = sync2_reg;
        rx_par_next = rx_par_reg ^ sync2_reg;
        rx_bit_next = rx_bit_reg + 4'h1;
        rx_cnt_next = BIT_LAST;
        if (rx_bit_reg == (nine ? 4'h8 : 4'h7)) begin
          rx_st_next = (!nine && cfg_reg[`CFG_PAR_EN]) ? serial_pkg::RX_PAR
                                                      : serial_pkg::RX_STOP;
        end
      end
      serial_pkg::RX_PAR: if (rx_cnt_reg == 16'h0000) begin
        rx_parity_error_flag_next = (rx_par_reg ^ sync2_reg) != cfg_reg[`CFG_PAR_ODD];
        rx_cnt_next  = BIT_LAST;
        rx_st_next   = serial_pkg::RX_STOP;
      end
      serial_pkg::RX_STOP: if (rx_cnt_reg == 16'h0000) begin
        rx_done    = 1'b1;
        rx_framing_error_flag    = !sync2_reg;
        rx_st_next = serial_pkg::RX_IDLE;
      end
      default: rx_st_next = serial_pkg::RX_IDLE;
    endcase
    if (flush) begin
      rx_st_next  = serial_pkg::RX_IDLE;
      rx_cnt_next = 16'h0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_reg   <= serial_pkg::RX_IDLE;
      rx_cnt_reg  <= 16'h0000;
      rx_bit_reg  <= 4'h0;
      rx_sh_reg   <= 9'h000;
      rx_par_reg  <= 1'b0;
      rx_parity_error_flag_reg <= 1'b0;
    end else begin
      rx_st_reg   <= rx_st_next;
      rx_cnt_reg  <= rx_cnt_next;
      rx_bit_reg  <= rx_bit_next;
      rx_sh_reg   <= rx_sh_next;
      rx_par_reg  <= rx_par_next;
      rx_parity_error_flag_reg <= rx_parity_error_flag_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive FIFO of {parity_error_flag, framing_error_flag, data9}
  assign keep    = rx_done && !(nine && address_detect_enable_reg && !rx_sh_reg[8]);
  assign push    = keep && !ovr_reg && (fcnt_reg != FULL) && !flush;
  // A full-buffer arrival in the clearing cycle sets the flag again: set wins
  assign ovr_set = keep && (fcnt_reg == FULL) && (!ovr_reg || flush);
  assign head    = (fcnt_reg != 3'h0) ? mem[rp_reg] : 11'h000;
  assign pop     = rd && hit && (paddr == `OFS_RXDATA) && (fcnt_reg != 3'h0);

  always_comb begin
    wp_next   = wp_reg;
    rp_next   = rp_reg;
    fcnt_next = fcnt_reg;
    if (push) wp_next = wp_reg + 2'h1;
    if (pop) rp_next = rp_reg + 2'h1;
    fcnt_next = fcnt_reg + {2'h0, push} - {2'h0, pop};
    if (flush) begin
      wp_next   = 2'h0;
      rp_next   = 2'h0;
      fcnt_next = 3'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_reg   <= 2'h0;
      rp_reg   <= 2'h0;
      fcnt_reg <= 3'h0;
      for (int i = 0; i < DEPTH; i++) mem[i] <= 11'h000;
    end else begin
      wp_reg   <= wp_next;
      rp_reg   <= rp_next;
      fcnt_reg <= fcnt_next;
      if (push) mem[wp_reg] <= {rx_parity_error_flag_reg, rx_framing_error_flag, rx_sh_reg};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter: one holding word, frame shifted out LSB first
  assign tx_load = (tx_st_reg == serial_pkg::TX_IDLE) && thv_reg;
  always_comb begin
    tx_st_next   = tx_st_reg;
    tx_sh_next   = tx_sh_reg;
    tx_left_next = tx_left_reg;
    tx_cnt_next  = tx_cnt_reg;
    th_next      = th_reg;
    thv_next     = thv_reg;
    tx_done      = 1'b0;
    case (tx_st_reg)
      serial_pkg::TX_IDLE: if (thv_reg) begin
        thv_next    = 1'b0;
        tx_cnt_next = BIT_LAST;
        tx_st_next  = serial_pkg::TX_SEND;
        if (nine) begin
          tx_sh_next   = {1'b1, th_reg[8], th_reg[7:0], 1'b0};
          tx_left_next = 4'd11;
        end else if (cfg_reg[`CFG_PAR_EN]) begin
          tx_sh_next   = {1'b1, (^th_reg[7:0]) ^ cfg_reg[`CFG_PAR_ODD], th_reg[7:0], 1'b0};
          tx_left_next = 4'd11;
        end else begin
          tx_sh_next   = {2'b11, th_reg[7:0], 1'b0};
          tx_left_next = 4'd10;
        end
      end
      serial_pkg::TX_SEND: begin
        tx_cnt_next = tx_cnt_reg - 16'h0001;
        if (tx_cnt_reg == 16'h0000) begin
          tx_sh_next   = {1'b1, tx_sh_reg[10:1]};
          tx_left_next = tx_left_reg - 4'h1;
          tx_cnt_next  = BIT_LAST;
          if (tx_left_reg == 4'h1) begin
            tx_done    = 1'b1;
            tx_st_next = serial_pkg::TX_IDLE;
          end
        end
      end
      default: tx_st_next = serial_pkg::TX_IDLE;
    endcase
    // A new write replaces a word not yet taken
    if (wr && (paddr == `OFS_TXDATA)) begin
      th_next  = pwdata[8:0];
      thv_next = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_reg   <= serial_pkg::TX_IDLE;
      tx_sh_reg   <= 11'h7ff;
      tx_left_reg <= 4'h0;
      tx_cnt_reg  <= 16'h0000;
      th_reg      <= 9'h000;
      thv_reg     <= 1'b0;
    end else begin
      tx_st_reg   <= tx_st_next;
      tx_sh_reg   <= tx_sh_next;
      tx_left_reg <= tx_left_next;
      tx_cnt_reg  <= tx_cnt_next;
      th_reg      <= th_next;
      thv_reg     <= thv_next;
    end
  end
  assign tx_line = tx_sh_reg[0];

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states
  assign wr      = psel && penable && pwrite;
  assign rd      = psel && penable && !pwrite;
  assign hit     = (paddr == `OFS_STATUS) || (paddr == `OFS_TXDATA) ||
                   (paddr == `OFS_RXDATA) || (paddr == `OFS_CONFIG) ||
                   (paddr == `OFS_IRQ_STAT) || (paddr == `OFS_IRQ_MASK);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign flush   = wr && (paddr == `OFS_STATUS) && ovr_reg && !pwdata[`ST_OVR];
  assign ev      = {tx_done, push && rx_parity_error_flag_reg, push && rx_framing_error_flag, ovr_set, push};
  assign irq     = |(ist_reg & imsk_reg);

  function automatic logic head_parity_error_flag_in();
    return rx_parity_error_flag_reg;
  endfunction : head_parity_error_flag_in

  // Read value, latched in the setup cycle
  always_comb begin
    rd_val = 32'h0000_0000;
    case (paddr)
      `OFS_STATUS: begin
        rd_val[`ST_ADDRESS_DETECT_ENABLE] = address_detect_enable_reg;
        rd_val[`ST_IDLE]  = (rx_st_reg == serial_pkg::RX_IDLE);
        rd_val[`ST_PARITY_ERROR_FLAG]  = head[10];
        rd_val[`ST_FRAMING_ERROR_FLAG]  = head[9];
        rd_val[`ST_OVR]   = ovr_reg;
        rd_val[`ST_AVAIL] = (fcnt_reg != 3'h0);
      end
      `OFS_RXDATA:   rd_val = {23'h000000, head[8:0]};
      `OFS_CONFIG:   rd_val = {29'h00000000, cfg_reg};
      `OFS_IRQ_STAT: rd_val = {27'h0000000, ist_reg};
      `OFS_IRQ_MASK: rd_val = {27'h0000000, imsk_reg};
      default:       rd_val = 32'h0000_0000; // Transmit data reads zero
    endcase
  end

  always_comb begin
    address_detect_enable_next  = address_detect_enable_reg;
    cfg_next    = cfg_reg;
    imsk_next   = imsk_reg;
    prdata_next = prdata_reg;
    if (psel && !penable) prdata_next = rd_val;
    if (wr && (paddr == `OFS_STATUS)) address_detect_enable_next = pwdata[`ST_ADDRESS_DETECT_ENABLE];
    if (wr && (paddr == `OFS_CONFIG)) cfg_next = pwdata[2:0];
    if (wr && (paddr == `OFS_IRQ_MASK)) imsk_next = pwdata[`NINTR-1:0];
    // Set wins over software clear
    ovr_next = ovr_set || (ovr_reg && !flush);
    ist_next = ((rd && (paddr == `OFS_IRQ_STAT)) ? '0 : ist_reg) | ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      address_detect_enable_reg  <= 1'b0;
      ovr_reg    <= 1'b0;
      cfg_reg    <= 3'h0;
      ist_reg    <= '0;
      imsk_reg   <= '0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      address_detect_enable_reg  <= address_detect_enable_next;
      ovr_reg    <= ovr_next;
      cfg_reg    <= cfg_next;
      ist_reg    <= ist_next;
      imsk_reg   <= imsk_next;
      prdata_reg <= prdata_next;
    end
  end
  assign prdata = prdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_ADDR_DROP: assert property (
    (keep == 1'b0) && rx_done && !pop |=> fcnt_reg == $past(fcnt_reg))
    else $error("address-detect drop changed fill");
  AST_IDLE_FLAG: assert property (
    rx_st_reg == serial_pkg::RX_IDLE && !sync2_reg && !flush |=>
      rx_st_reg != serial_pkg::RX_IDLE)
    else $error("receiver did not leave idle");
  AST_HEAD_FLAGS: assert property (
    fcnt_reg == 3'h0 |-> rd_val[`ST_PARITY_ERROR_FLAG:`ST_FRAMING_ERROR_FLAG] == 2'b00 || paddr != `OFS_STATUS)
    else $error("error flags set with empty buffer");
  AST_OVR_SET: assert property (
    keep && fcnt_reg == FULL |=> ovr_reg)
    else $error("overrun not flagged");
  AST_OVR_HOLD: assert property (
    ovr_reg && !flush |=> ovr_reg)
    else $error("overrun dropped without clear");
  AST_FLUSH: assert property (
    flush |=> fcnt_reg == 3'h0 && rx_st_reg == serial_pkg::RX_IDLE)
    else $error("clear did not empty receiver");
  AST_AVAIL: assert property (
    push |=> fcnt_reg != 3'h0)
    else $error("pushed char not available");
  AST_TX_START: assert property (
    tx_load |=> !tx_line [*2])
    else $error("start bit missing");
  AST_RX_UPPER: assert property (
    psel && !penable && paddr == `OFS_RXDATA |=> prdata[31:9] == 23'h000000)
    else $error("receive upper bits not zero");
  AST_DEPTH: assert property (
    fcnt_reg <= FULL)
    else $error("fifo over depth");
  AST_POP: assert property (
    pop && !push |=> fcnt_reg == $past(fcnt_reg) - 3'h1)
    else $error("read did not pop");
endmodule : serial_port

// [rtl/serial_defs.svh]
// Offsets, field positions and counts of the serial port.
// Assumes byte addresses on an APB bus with 32-bit data.
`ifndef SERIAL_DEFS_SVH
`define SERIAL_DEFS_SVH
`define OFS_STATUS    8'h00
`define OFS_TXDATA    8'h04
`define OFS_RXDATA    8'h08
`define OFS_CONFIG    8'h0c
`define OFS_IRQ_STAT  8'h10
`define OFS_IRQ_MASK  8'h14
`define ST_ADDRESS_DETECT_ENABLE      5
`define ST_IDLE       4
`define ST_PARITY_ERROR_FLAG       3
`define ST_FRAMING_ERROR_FLAG       2
`define ST_OVR        1
`define ST_AVAIL      0
`define CFG_NINE      0
`define CFG_PAR_EN    1
`define CFG_PAR_ODD   2
`define NINTR         5
`define RX_DEPTH      4
`define BAUD_DIV      16
`endif

// [rtl/serial_pkg.sv]
// Types shared by the serial port files.
// Assumes nothing of its surroundings.
package serial_pkg;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;
  typedef enum logic {TX_IDLE, TX_SEND} tx_state_t;
endpackage : serial_pkg

// [bench/serial_peer.sv]
// Remote serial transceiver model: frames characters onto rx_line, decodes tx_line.
// Assumes CLKS_PER_BIT pclk cycles per bit and a line that idles high.
`timescale 1ns/1ps
module serial_peer #(
  parameter int CLKS_PER_BIT = 16
) (
  input  wire logic pclk,
  input  wire logic tx_line,
  output logic      rx_line
);
  // Line idles high between frames
  initial rx_line = 1'b1;
  ////////////////////////////////////////////////////////////////////////////////
  // One bit for a full bit time, changed just after a rising edge
  task automatic put_bit(input logic b);
    @(posedge pclk);
    rx_line <= b;
    repeat (CLKS_PER_BIT - 1) @(posedge pclk);
  endtask : put_bit
  // Start, nb data bits LSB first, parity if par >= 0, stop, two idle bits
  task automatic send(input logic [8:0] d, input int nb, input int par, input logic stop);
    put_bit(1'b0);
    for (int i = 0; i < nb; i++) put_bit(d[i]);
    if (par >= 0) put_bit(par[0]);
    put_bit(stop);
    put_bit(1'b1);
    put_bit(1'b1);
  endtask : send
  // Nine samples taken mid-bit after the falling start edge
  task automatic catch_char(output logic [8:0] q);
    @(negedge tx_line);
    repeat (CLKS_PER_BIT + CLKS_PER_BIT / 2) @(posedge pclk);
    for (int i = 0; i < 9; i++) begin
      q[i] = tx_line;
      repeat (CLKS_PER_BIT) @(posedge pclk);
    end
  endtask : catch_char
endmodule : serial_peer

// [bench/uart_rx_status_and_data_regs_test.sv]
// Self-checking bench of the serial port registers, receiver and transmitter.
// Assumes serial_port with an APB slave and serial_peer on the serial line.
`timescale 1ns/1ps
`include "serial_defs.svh"
module uart_rx_status_and_data_regs_test;
  localparam int CPB = 16;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic s;} row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        rx_line, tx_line, irq, slv;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [8:0]  got;
  logic [7:0]  fill [5];
  row_t        rows [9];
  int          num_errors, n_compared;

  serial_port #(.CLKS_PER_BIT(CPB), .DEPTH(`RX_DEPTH)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_line(rx_line), .tx_line(tx_line), .irq(irq));
  serial_peer #(.CLKS_PER_BIT(CPB)) peer (.pclk(pclk), .tx_line(tx_line), .rx_line(rx_line));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 40 MHz
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // Verdict and end of run
  task automatic close_out;
    $display("Counts: %0d compared, %0d mismatched", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  // Word and bit comparisons
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk_word
  task automatic chk_bit(input logic g, input logic e);
    chk_word({31'h0, g}, {31'h0, e});
  endtask : chk_bit
  // APB transfer: setup, access held until pready at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    slv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk_word(q, e);
  endtask : rd_chk
  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    repeat (30000) @(posedge pclk);
    num_errors++;
    $display("[FAIL] t=%0t watchdog got %h exp %h", $time, 1'b1, 1'b0);
    close_out();
  end
  // Main sequence
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    presetn = 1'b0;
    num_errors = 0;
    n_compared = 0;
    fill = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
    rows = '{'{1'b0, `OFS_STATUS, 32'h0, 32'h10, 1'b0}, '{1'b0, `OFS_RXDATA, 32'h0, 32'h0, 1'b0},
             '{1'b0, `OFS_TXDATA, 32'h0, 32'h0, 1'b0}, '{1'b1, `OFS_STATUS, 32'h20, 32'h0, 1'b0},
             '{1'b0, `OFS_STATUS, 32'h0, 32'h30, 1'b0}, '{1'b1, `OFS_STATUS, 32'h22, 32'h0, 1'b0},
             '{1'b0, `OFS_STATUS, 32'h0, 32'h30, 1'b0}, '{1'b1, `OFS_STATUS, 32'h0, 32'h0, 1'b0},
             '{1'b0, 8'h20, 32'h0, 32'h0, 1'b1}};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk_word(q, rows[i].e);
      chk_bit(slv, rows[i].s);
    end
    $display("test registers done");
    // Idle flag drops mid-frame, data available after the stop bit
    wr(`OFS_CONFIG, 32'h0);
    fork
      peer.send(9'h0a5, 8, -1, 1'b1);
    join_none
    repeat (3 * CPB) @(posedge pclk);
    rd_chk(`OFS_STATUS, 32'h00);
    wait fork;
    rd_chk(`OFS_STATUS, 32'h11);
    rd_chk(`OFS_RXDATA, 32'ha5);
    rd_chk(`OFS_STATUS, 32'h10);
    $display("test receive done");
    // Four stored, fifth overruns; fourth has a low stop bit
    foreach (fill[i]) peer.send({1'b0, fill[i]}, 8, -1, i != 3);
    repeat (12 * CPB) @(posedge pclk);
    rd_chk(`OFS_STATUS, 32'h13);
    for (int i = 0; i < 3; i++) rd_chk(`OFS_RXDATA, {24'h0, fill[i]});
    rd_chk(`OFS_STATUS, 32'h17);
    rd_chk(`OFS_RXDATA, 32'h44);
    rd_chk(`OFS_STATUS, 32'h12);
    wr(`OFS_STATUS, 32'h0);
    rd_chk(`OFS_STATUS, 32'h10);
    $display("test overrun done");
    // Even parity: wrong parity on the first character only
    wr(`OFS_CONFIG, 32'h2);
    peer.send(9'h05a, 8, !(^8'h5a), 1'b1);
    peer.send(9'h007, 8, ^8'h07, 1'b1);
    rd_chk(`OFS_STATUS, 32'h19);
    rd_chk(`OFS_RXDATA, 32'h5a);
    rd_chk(`OFS_STATUS, 32'h11);
    rd_chk(`OFS_RXDATA, 32'h07);
    $display("test parity done");
    // Address detect keeps only ninth-bit-set characters, and only in 9-bit mode
    wr(`OFS_CONFIG, 32'h1);
    wr(`OFS_STATUS, 32'h20);
    peer.send(9'h0ab, 9, -1, 1'b1);
    peer.send(9'h1cd, 9, -1, 1'b1);
    rd_chk(`OFS_STATUS, 32'h31);
    rd_chk(`OFS_RXDATA, 32'h1cd);
    rd_chk(`OFS_STATUS, 32'h30);
    wr(`OFS_CONFIG, 32'h0);
    peer.send(9'h03c, 8, -1, 1'b1);
    rd_chk(`OFS_RXDATA, 32'h3c);
    wr(`OFS_STATUS, 32'h0);
    $display("test address detect done");
    // Transmit nine bits, then eight; frame done interrupt masked, unmasked, cleared
    wr(`OFS_CONFIG, 32'h1);
    apb(1'b0, `OFS_IRQ_STAT, 32'h0);
    wr(`OFS_IRQ_MASK, 32'h0);
    wr(`OFS_TXDATA, 32'hffff_fda5);
    peer.catch_char(got);
    chk_word({23'h0, got}, 32'h1a5);
    repeat (3 * CPB) @(negedge pclk);
    chk_bit(irq, 1'b0);
    wr(`OFS_IRQ_MASK, 32'h10);
    @(negedge pclk);
    chk_bit(irq, 1'b1);
    rd_chk(`OFS_IRQ_STAT, 32'h10);
    @(negedge pclk);
    chk_bit(irq, 1'b0);
    wr(`OFS_CONFIG, 32'h0);
    wr(`OFS_TXDATA, 32'h15c);
    peer.catch_char(got);
    chk_word({23'h0, got}, 32'h15c);
    $display("test transmit done");
    // Reset in mid-run empties the buffer and zeroes receive data
    peer.send(9'h0e7, 8, -1, 1'b1);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(`OFS_STATUS, 32'h10);
    rd_chk(`OFS_RXDATA, 32'h0);
    $display("test reset done");
    close_out();
  end
endmodule : uart_rx_status_and_data_regs_test
